// ### bench/gpis_gpio_int_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port-level checker of the pin interrupt block
// ----------------------------------------------------------------------------
module gpis_gpio_int_asserts (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] port_a_upper_pins,
  input wire logic [31:0] port_d_pins,
  input wire logic [3:0]  port_e_pins,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // A request is taken on the edge where it meets a high waitrequest.
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_s(a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence
  sequence mask_off_s;
    avs_write && !avs_waitrequest && avs_address == 12'h244 && avs_byteenable[0] && avs_writedata[2:0] == 3'h0;
  endsequence

  wait_answer_a: assert property (taken_s |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a taken request");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  read_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("readdata changed without a read");
  unmapped_zero_a: assert property (rd_s(12'h100) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  e_pend_upper_a: assert property (rd_s(12'h228) |=> avs_readdata[31:4] == 28'h0)
    else $error("port E pending upper bits not zero");
  e_mask_upper_a: assert property (rd_s(12'h22c) |=> avs_readdata[31:4] == 28'h0)
    else $error("port E mask upper bits not zero");
  irq_masked_a: assert property (mask_off_s |-> ##[1:2] !irq)
    else $error("irq stayed high with all summaries masked");
  reset_idle_a: assert property (@(posedge core_clk) disable iff (1'b0) $rose(rst_n) |-> avs_waitrequest && !irq)
    else $error("outputs not idle at reset release");
endmodule

bind gpis_gpio_int gpis_gpio_int_asserts gpis_gpio_int_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_a_upper_pins(port_a_upper_pins),
  .port_d_pins(port_d_pins), .port_e_pins(port_e_pins), .irq(irq)
);
`default_nettype wire

// ### bench/gpis_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin driver standing for the board behind ports A, D and E
// ----------------------------------------------------------------------------
module gpis_pin_model (
  input  wire logic        core_clk,
  input  wire logic [51:0] want,
  output var  logic [15:0] port_a_upper_pins,
  output var  logic [31:0] port_d_pins,
  output var  logic [3:0]  port_e_pins
);
  // Pins start low so the detectors never see an unknown level.
  initial {port_e_pins, port_d_pins, port_a_upper_pins} = 52'h0;

  // Levels move only just after a rising edge, as synchronised board inputs do.
  always @(posedge core_clk) begin
    {port_e_pins, port_d_pins, port_a_upper_pins} <= want;
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpis_consts.vh"
module tb_top;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, v;
  logic [3:0]  avs_byteenable, o, n;
  logic [15:0] pa;
  logic [31:0] pd;
  logic [3:0]  pe;
  logic [51:0] want;
  integer      bad_count, n_tests, seed, i, c;

  gpis_gpio_int gpis_gpio_int_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_a_upper_pins(pa),
    .port_d_pins(pd), .port_e_pins(pe), .irq(irq));
  gpis_pin_model gpis_pin_model_inst (.core_clk(core_clk), .want(want), .port_a_upper_pins(pa),
    .port_d_pins(pd), .port_e_pins(pe));

  // ----------------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (50000) @(posedge core_clk);
    bad_count = bad_count + 1;
    wrap_up;
  end
  task wrap_up;
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------------------
  // Avalon master; waitrequest and readdata are taken at the rising edge.
  // ----------------------------------------------------------------------------
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    integer k;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    k = 0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      k = k + 1;
      @(posedge core_clk);
    end
    if (k == 20) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk("readdata", e, q);
  endtask
  task wt(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  // Port E pending after pins move from o to n under trigger code t.
  function logic [3:0] e_exp(input logic [1:0] t, input logic [3:0] a, input logic [3:0] b);
    case (t)
      2'h0: e_exp = b;
      2'h1: e_exp = ~b;
      2'h2: e_exp = ~a & b;
      default: e_exp = a & ~b;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    seed = 27715;
    bad_count = 0;
    n_tests = 0;
    want = 52'h0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(`GPIS_OFF_D_MASK, 32'h0);
    rd_chk(`GPIS_OFF_E_MASK, 32'h0);
    rd_chk(`GPIS_OFF_A_TYPE, 32'h0);
    rd_chk(`GPIS_OFF_CLK_SEL, 32'h0);
    rd_chk(12'h100, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      wr(`GPIS_OFF_D_MASK, v);
      rd_chk(`GPIS_OFF_D_MASK, v);
      wr(`GPIS_OFF_E_MASK, v);
      rd_chk(`GPIS_OFF_E_MASK, v & 32'h0000_000f);
      wr(`GPIS_OFF_A_TYPE, v);
      rd_chk(`GPIS_OFF_A_TYPE, v);
    end
    // Level detection on port D, both polarities; pending ignores writes.
    wr(`GPIS_OFF_CLK_SEL, 32'h7);
    v = $random(seed);
    want[47:16] <= v;
    wt(8);
    wr(`GPIS_OFF_D_PEND, ~v);
    rd_chk(`GPIS_OFF_D_PEND, v);
    wr(`GPIS_OFF_D_TYPE_LO, 32'h5555_5555);
    wr(`GPIS_OFF_D_TYPE_HI, 32'h5555_5555);
    wt(8);
    rd_chk(`GPIS_OFF_D_PEND, ~v);
    // Every trigger code on port E; edges must stay latched after the pins return.
    for (c = 0; c < 4; c = c + 1) begin
      o = 4'($random(seed));
      n = 4'($random(seed));
      wr(`GPIS_OFF_E_TYPE, {24'h0, {4{c[1:0]}}});
      want[51:48] <= o;
      wt(8);
      wr(`GPIS_OFF_STATUS, 32'h4);
      want[51:48] <= n;
      wt(8);
      rd_chk(`GPIS_OFF_E_PEND, {28'h0, e_exp(c[1:0], o, n)});
      want[51:48] <= o;
      wt(8);
      rd_chk(`GPIS_OFF_E_PEND, {28'h0, (c < 2) ? e_exp(c[1:0], n, o) : o ^ n});
    end
    // Pin 31 rising and pin 16 low level sit at the two ends of the type word.
    wr(`GPIS_OFF_A_TYPE, 32'h8000_0001);
    wt(8);
    wr(`GPIS_OFF_STATUS, 32'h1);
    rd_chk(`GPIS_OFF_A_PEND, 32'h1);
    want[15:0] <= 16'hffff;
    wt(8);
    rd_chk(`GPIS_OFF_A_PEND, 32'hfffe);
    // Interrupt on one random port D pin: pin mask, summary mask, then clear.
    wr(`GPIS_OFF_D_TYPE_LO, 32'haaaa_aaaa);
    wr(`GPIS_OFF_D_TYPE_HI, 32'haaaa_aaaa);
    want[47:16] <= 32'h0;
    wt(8);
    wr(`GPIS_OFF_STATUS, 32'h7);
    wr(`GPIS_OFF_D_MASK, 32'h0);
    wr(`GPIS_OFF_IRQ_MASK, 32'h2);
    i = {$random(seed)} % 32;
    want[16 + i] <= 1'b1;
    wt(8);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk(`GPIS_OFF_D_PEND, 32'h1 << i);
    wr(`GPIS_OFF_D_MASK, 32'h1 << i);
    wt(4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`GPIS_OFF_IRQ_MASK, 32'h0);
    wt(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`GPIS_OFF_IRQ_MASK, 32'h2);
    wt(4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`GPIS_OFF_STATUS, 32'h2);
    wt(3);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk(`GPIS_OFF_D_PEND, 32'h0);
    // Slow sampling on port E still catches a level, within 700 reads of 3 cycles, about 1.4 slow periods.
    wr(`GPIS_OFF_CLK_SEL, 32'h3);
    wr(`GPIS_OFF_E_TYPE, 32'h0);
    want[51:48] <= 4'ha;
    q = 32'h0;
    for (i = 0; i < 700 && q !== 32'ha; i = i + 1) bus(1'b0, `GPIS_OFF_E_PEND, 32'h0, q);
    chk("slow sample", 32'ha, q);
    wrap_up;
  end
endmodule
`default_nettype wire

// ### hw/gpis_gpio_int.v
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpis_consts.vh"

// What this block does
// R1: Port D pending register, read only, bit n shows pin n request active.
// R2: Port D mask register, read-write, reset zero; a one lets pin request count.
// R3: Port E pending register, bits 3:0 per pin, bits 31:4 read zero.
// R4: Port E mask register, read-write, reset zero, bits 3:0, upper bits reserved.
// R5: Trigger code 00 high level, 01 low level, 10 rising, 11 falling edge.
// R6: Port A pins 16..31 type register, two bits per pin, pin 31 on top, reset zero.
// R7: Summary pending flag clears on writing one; software clears edge-triggered flags.
// R8: Per-port sample clock select: 0 gives 32 kHz, 1 gives 24 MHz, reset 0.
// R9: Edge requests stay pending until cleared; summary sets on any unmasked pending.
module gpis_gpio_int (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [15:0] port_a_upper_pins,
  input  wire [31:0] port_d_pins,
  input  wire [3:0]  port_e_pins,
  output reg         irq
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  reg  [31:0]                port_d_mask_bits_ff;
  reg  [3:0]                 port_e_mask_bits_ff;
  reg  [31:0]                type_a_ff;
  reg  [31:0]                type_d_lo_ff;
  reg  [31:0]                type_d_hi_ff;
  reg  [7:0]                 type_e_ff;
  reg  [2:0]                 status_ff;
  reg  [2:0]                 irq_mask_ff;
  reg  [2:0]                 clk_sel_ff;
  reg  [`GPIS_ACC_W-1:0]     acc_slow_ff;
  reg  [`GPIS_ACC_W-1:0]     acc_fast_ff;
  reg                        tick_slow_ff;
  reg                        tick_fast_ff;

  reg  [31:0]                nxt_readdata;
  reg  [`GPIS_ACC_W-1:0]     nxt_acc_slow;
  reg  [`GPIS_ACC_W-1:0]     nxt_acc_fast;
  reg                        nxt_tick_slow;
  reg                        nxt_tick_fast;

  wire [`GPIS_ACC_W-1:0]     sum_slow;
  wire [`GPIS_ACC_W-1:0]     sum_fast;
  wire [31:0]                be_mask;
  wire                       req_new;
  wire                       wr_go;
  wire [2:0]                 w1c;
  wire [2:0]                 set_ev;
  wire [2:0]                 nxt_status;
  wire [2:0]                 port_tick;
  wire [`GPIS_NPIN-1:0]      all_pins;
  wire [`GPIS_NPIN-1:0]      pin_tick;
  wire [`GPIS_NPIN-1:0]      pin_clear;
  wire [2*`GPIS_NPIN-1:0]    all_types;
  wire [`GPIS_NPIN-1:0]      pin_req;
  wire [`GPIS_A_W-1:0]       port_a_pending_bits;
  wire [`GPIS_D_W-1:0]       port_d_pending_bits;
  wire [`GPIS_E_W-1:0]       port_e_pending_bits;

  // ----------------------------------------------------------------------------
  // Sample clock ticks
  // ----------------------------------------------------------------------------
  // Both sample rates come from core_clk by phase accumulation, so the tick
  // spacing jitters by one cycle but the long-run rate is exact.
  assign sum_slow = acc_slow_ff + `GPIS_SLOW_HZ;
  assign sum_fast = acc_fast_ff + `GPIS_FAST_HZ;

  // Wrap each accumulator at the core rate and flag a tick on the wrap.
  always @* begin
    nxt_acc_slow  = sum_slow;
    nxt_tick_slow = 1'b0;
    if (sum_slow >= `GPIS_CLK_HZ) begin
      nxt_acc_slow  = sum_slow - `GPIS_CLK_HZ;
      nxt_tick_slow = 1'b1;
    end
    nxt_acc_fast  = sum_fast;
    nxt_tick_fast = 1'b0;
    if (sum_fast >= `GPIS_CLK_HZ) begin
      nxt_acc_fast  = sum_fast - `GPIS_CLK_HZ;
      nxt_tick_fast = 1'b1;
    end
  end

  // Accumulator and tick registers.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      acc_slow_ff  <= {`GPIS_ACC_W{1'b0}};
      acc_fast_ff  <= {`GPIS_ACC_W{1'b0}};
      tick_slow_ff <= 1'b0;
      tick_fast_ff <= 1'b0;
    end else begin
      acc_slow_ff  <= nxt_acc_slow;
      acc_fast_ff  <= nxt_acc_fast;
      tick_slow_ff <= nxt_tick_slow;
      tick_fast_ff <= nxt_tick_fast;
    end
  end

  // Each port picks its sample rate from its own select bit.
  assign port_tick = (clk_sel_ff & {3{tick_fast_ff}}) | (~clk_sel_ff & {3{tick_slow_ff}}); // R8

  // ----------------------------------------------------------------------------
  // Per-pin detectors
  // ----------------------------------------------------------------------------
  // Pins of the three ports are laid side by side so one loop serves them all.
  assign all_pins  = {port_e_pins, port_d_pins, port_a_upper_pins};
  assign all_types = {type_e_ff, type_d_hi_ff, type_d_lo_ff, type_a_ff}; // R6
  assign pin_tick  = {{`GPIS_E_W{port_tick[`GPIS_PORT_E]}},
                      {`GPIS_D_W{port_tick[`GPIS_PORT_D]}},
                      {`GPIS_A_W{port_tick[`GPIS_PORT_A]}}};
  // Clearing a port's summary flag also clears that port's latched edges.
  assign pin_clear = {{`GPIS_E_W{w1c[`GPIS_PORT_E]}},
                      {`GPIS_D_W{w1c[`GPIS_PORT_D]}},
                      {`GPIS_A_W{w1c[`GPIS_PORT_A]}}}; // R7

  genvar gi;
  generate
    for (gi = 0; gi < `GPIS_NPIN; gi = gi + 1) begin : g_pin
      gpis_pin_det u_det (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .pin         (all_pins[gi]),
        .sample_tick (pin_tick[gi]),
        .trig_type   (all_types[2*gi+1:2*gi]),
        .clear_edge  (pin_clear[gi]),
        .req         (pin_req[gi])
      );
    end
  endgenerate

  assign port_a_pending_bits = pin_req[`GPIS_A_BASE +: `GPIS_A_W];
  assign port_d_pending_bits = pin_req[`GPIS_D_BASE +: `GPIS_D_W]; // R1
  assign port_e_pending_bits = pin_req[`GPIS_E_BASE +: `GPIS_E_W]; // R3

  // ----------------------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------------------
  // waitrequest idles high; a new request drops it for one cycle, and the
  // write lands on the edge where the master sees it low.
  assign req_new = (avs_read | avs_write) & avs_waitrequest;
  assign wr_go   = avs_write & ~avs_waitrequest;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Read mux; unmapped and misaligned addresses read zero.
  always @* begin
    case (avs_address)
      `GPIS_OFF_D_PEND:    nxt_readdata = port_d_pending_bits; // R1
      `GPIS_OFF_D_MASK:    nxt_readdata = port_d_mask_bits_ff;
      `GPIS_OFF_E_PEND:    nxt_readdata = {28'h0000000, port_e_pending_bits}; // R3
      `GPIS_OFF_E_MASK:    nxt_readdata = {28'h0000000, port_e_mask_bits_ff}; // R4
      `GPIS_OFF_A_TYPE:    nxt_readdata = type_a_ff;
      `GPIS_OFF_STATUS:    nxt_readdata = {29'h00000000, status_ff};
      `GPIS_OFF_IRQ_MASK:  nxt_readdata = {29'h00000000, irq_mask_ff};
      `GPIS_OFF_CLK_SEL:   nxt_readdata = {29'h00000000, clk_sel_ff};
      `GPIS_OFF_A_PEND:    nxt_readdata = {16'h0000, port_a_pending_bits};
      `GPIS_OFF_D_TYPE_LO: nxt_readdata = type_d_lo_ff;
      `GPIS_OFF_D_TYPE_HI: nxt_readdata = type_d_hi_ff;
      `GPIS_OFF_E_TYPE:    nxt_readdata = {24'h000000, type_e_ff};
      default:             nxt_readdata = `GPIS_RST_WORD;
    endcase
  end

  // Handshake and read data registers; data is caught when the request is
  // first seen and stands until the next read request.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `GPIS_RST_WORD;
    end else begin
      avs_waitrequest <= ~req_new;
      if (req_new && avs_read) begin
        avs_readdata <= nxt_readdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------------------
  // Byte enables gate every write; read-only offsets ignore writes.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      port_d_mask_bits_ff <= `GPIS_RST_WORD; // R2
      port_e_mask_bits_ff <= `GPIS_RST_E; // R4
      type_a_ff           <= `GPIS_RST_WORD; // R6
      type_d_lo_ff        <= `GPIS_RST_WORD;
      type_d_hi_ff        <= `GPIS_RST_WORD;
      type_e_ff           <= `GPIS_RST_E_TYPE;
      irq_mask_ff         <= `GPIS_RST_PORTS;
      clk_sel_ff          <= `GPIS_RST_PORTS; // R8
    end else if (wr_go) begin
      case (avs_address)
        `GPIS_OFF_D_MASK: begin
          port_d_mask_bits_ff <= (port_d_mask_bits_ff & ~be_mask) | (avs_writedata & be_mask); // R2
        end
        `GPIS_OFF_E_MASK: begin
          if (avs_byteenable[0]) begin
            port_e_mask_bits_ff <= avs_writedata[3:0]; // R4
          end
        end
        `GPIS_OFF_A_TYPE: begin
          type_a_ff <= (type_a_ff & ~be_mask) | (avs_writedata & be_mask); // R6
        end
        `GPIS_OFF_D_TYPE_LO: begin
          type_d_lo_ff <= (type_d_lo_ff & ~be_mask) | (avs_writedata & be_mask);
        end
        `GPIS_OFF_D_TYPE_HI: begin
          type_d_hi_ff <= (type_d_hi_ff & ~be_mask) | (avs_writedata & be_mask);
        end
        `GPIS_OFF_E_TYPE: begin
          if (avs_byteenable[0]) begin
            type_e_ff <= avs_writedata[7:0];
          end
        end
        `GPIS_OFF_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            irq_mask_ff <= avs_writedata[2:0];
          end
        end
        `GPIS_OFF_CLK_SEL: begin
          if (avs_byteenable[0]) begin
            clk_sel_ff <= avs_writedata[2:0]; // R8
          end
        end
        default: begin
          irq_mask_ff <= irq_mask_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Summary pending flags and interrupt
  // ----------------------------------------------------------------------------
  // A port flag sets while any unmasked pin request of that port is pending.
  // Port A upper pins have no mask here, so every request counts.
  assign set_ev[`GPIS_PORT_A] = |port_a_pending_bits;
  assign set_ev[`GPIS_PORT_D] = |(port_d_pending_bits & port_d_mask_bits_ff); // R9
  assign set_ev[`GPIS_PORT_E] = |(port_e_pending_bits & port_e_mask_bits_ff); // R9

  // Writing a one clears a flag. The pin requests seen in the clearing cycle
  // are the ones being cleared, so they must not hold the flag up; a source
  // that is still active raises it again on the next edge, so nothing is lost.
  assign w1c = (wr_go && avs_address == `GPIS_OFF_STATUS && avs_byteenable[0]) ?
               avs_writedata[2:0] : `GPIS_RST_PORTS; // R7
  assign nxt_status = (status_ff | set_ev) & ~w1c; // R7

  // Status flags and the registered interrupt line.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      status_ff <= `GPIS_RST_PORTS;
      irq       <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq       <= |(status_ff & irq_mask_ff);
    end
  end

endmodule
`default_nettype wire

// ### hw/gpis_pin_det.v
`timescale 1ns/1ps
`default_nettype none
`include "gpis_consts.vh"

module gpis_pin_det (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       pin,
  input  wire       sample_tick,
  input  wire [1:0] trig_type,
  input  wire       clear_edge,
  output wire       req
);

  reg  samp_ff;
  reg  primed_ff;
  reg  edge_ff;
  reg  nxt_edge;
  wire is_edge;
  wire rise;
  wire fall;
  wire hit;
  wire level_req;

  // ----------------------------------------------------------------------------
  // Sampling and detection
  // ----------------------------------------------------------------------------
  // The pin is only looked at on a sample tick; primed_ff hides the first
  // sample so that a pin already high at reset is not seen as a rising edge.
  assign is_edge   = trig_type[1];
  assign rise      = sample_tick & primed_ff & pin & ~samp_ff;
  assign fall      = sample_tick & primed_ff & ~pin & samp_ff;
  assign hit       = (trig_type == `GPIS_TYPE_RISE) ? rise : fall; // R5
  assign level_req = (trig_type == `GPIS_TYPE_HIGH) ? samp_ff : ~samp_ff; // R5

  // An edge stays latched until cleared; a new edge in the clearing cycle wins.
  always @* begin
    if (!is_edge) begin
      nxt_edge = 1'b0;
    end else if (hit) begin
      nxt_edge = 1'b1; // R9
    end else if (clear_edge) begin
      nxt_edge = 1'b0; // R7
    end else begin
      nxt_edge = edge_ff;
    end
  end

  // Sample register, priming flag and edge latch.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      samp_ff   <= 1'b0;
      primed_ff <= 1'b0;
      edge_ff   <= 1'b0;
    end else begin
      if (sample_tick) begin
        samp_ff   <= pin;
        primed_ff <= 1'b1;
      end
      edge_ff <= nxt_edge;
    end
  end

  // A level request follows the last sample; an edge request is the latch.
  assign req = is_edge ? edge_ff : (primed_ff & level_req); // R9

endmodule
`default_nettype wire

// ### include/gpis_consts.vh
// ----------------------------------------------------------------------------
// Constants of the GPIO pin interrupt status block
// ----------------------------------------------------------------------------
`ifndef GPIS_CONSTS_VH
`define GPIS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------------
`define GPIS_ADDR_W        12
`define GPIS_OFF_D_PEND    12'h220
`define GPIS_OFF_D_MASK    12'h224
`define GPIS_OFF_E_PEND    12'h228
`define GPIS_OFF_E_MASK    12'h22c
`define GPIS_OFF_A_TYPE    12'h230
`define GPIS_OFF_STATUS    12'h240
`define GPIS_OFF_IRQ_MASK  12'h244
`define GPIS_OFF_CLK_SEL   12'h248
`define GPIS_OFF_A_PEND    12'h24c
`define GPIS_OFF_D_TYPE_LO 12'h250
`define GPIS_OFF_D_TYPE_HI 12'h254
`define GPIS_OFF_E_TYPE    12'h258

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define GPIS_PORT_A        0
`define GPIS_PORT_D        1
`define GPIS_PORT_E        2
`define GPIS_NPORT         3
`define GPIS_A_W           16
`define GPIS_D_W           32
`define GPIS_E_W           4
`define GPIS_A_BASE        0
`define GPIS_D_BASE        16
`define GPIS_E_BASE        48
`define GPIS_NPIN          52
`define GPIS_RST_WORD      32'h0000_0000
`define GPIS_RST_PORTS     3'h0
`define GPIS_RST_E         4'h0
`define GPIS_RST_E_TYPE    8'h00

// ----------------------------------------------------------------------------
// Trigger type codes, two bits per pin
// ----------------------------------------------------------------------------
`define GPIS_TYPE_HIGH     2'h0
`define GPIS_TYPE_LOW      2'h1
`define GPIS_TYPE_RISE     2'h2
`define GPIS_TYPE_FALL     2'h3

// ----------------------------------------------------------------------------
// Sample clock rates in Hz, made from core_clk by phase accumulation
// ----------------------------------------------------------------------------
`define GPIS_ACC_W         27
`define GPIS_CLK_HZ        27'h2faf080
`define GPIS_SLOW_HZ       27'h0008000
`define GPIS_FAST_HZ       27'h16e3600

`endif
